// *** design/hbc_core.sv ***
/*
  8-bit harvard core datapath: fetch/execute pipeline, alu, working
  register, status, indirect pointer, program counter and two-level stack.
  assumes synchronous program flash (data valid one clock after address)
  and asynchronous data ram reads sampled in the same clock as read enable.
*/
// Summary of operation
// - separate program and data buses, concurrent use
// - every opcode is one 12-bit word
// - 12-bit program port, one word per cycle
// - next fetch overlaps current execution
// - single-cycle instructions, branches take longer
// - 1024x12 program, up to 112 data bytes
// - special registers and pc in data space
// - direct and indirect data addressing supported
// - every operation works on every register
// - 8-bit alu: add, subtract, shift, logic
// - arithmetic is two's complement
// - two operands: working register plus file/literal
// - single operand: working register or file
// - working register has no data address
// - alu updates carry, nibble-carry, zero flags
// - subtraction carries are inverted borrows
// - clock divided into four phases Q1-Q4
// - operand read Q2, result written Q4
// - pc change discards fetched word, two cycles
`timescale 1ns/1ps
`include "hbc_defines.svh"

module hbc_core (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // program memory bus
  output logic [`HBC_PADDR_W-1:0]        progAddr,
  input  wire logic [`HBC_INSTR_W-1:0]   progRdata,
  // data memory bus
  output logic [`HBC_DADDR_W-1:0]        dataAddr,
  output logic                           dataRdEn,
  input  wire logic [`HBC_DATA_W-1:0]    dataRdata,
  output logic                           dataWrEn,
  output logic [`HBC_DATA_W-1:0]         dataWdata,
  // observation
  output logic [`HBC_DATA_W-1:0]         wReg,
  output logic [`HBC_DATA_W-1:0]         status
);

  // add with nibble carry: {carry7, carry3, sum}
  function automatic logic [9:0] hbc_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : hbc_add

  // sequencing state
  hbc_pkg::hbc_phase_e          phase;          // current q phase
  hbc_pkg::hbc_phase_e          next_phase;
  // datapath state
  logic [`HBC_PADDR_W-1:0]      pc;             // next fetch address
  logic [`HBC_PADDR_W-1:0]      next_pc;
  logic [`HBC_PADDR_W-1:0]      next_progAddr;
  logic [`HBC_INSTR_W-1:0]      ir;             // instruction in execution
  logic [`HBC_INSTR_W-1:0]      next_ir;
  logic                         irValid;        // low for discarded slot
  logic                         next_irValid;
  logic [`HBC_DATA_W-1:0]       next_wReg;
  logic [`HBC_DATA_W-1:0]       next_status;
  logic [`HBC_DATA_W-1:0]       pointer;        // indirect pointer
  logic [`HBC_DATA_W-1:0]       next_pointer;
  logic [`HBC_DATA_W-1:0]       operand;        // file operand latched in Q2
  logic [`HBC_DATA_W-1:0]       next_operand;
  logic [`HBC_PADDR_W-1:0]      stack0;         // top of return stack
  logic [`HBC_PADDR_W-1:0]      next_stack0;
  logic [`HBC_PADDR_W-1:0]      stack1;
  logic [`HBC_PADDR_W-1:0]      next_stack1;
  logic [`HBC_DADDR_W-1:0]      next_dataAddr;
  logic                         next_dataRdEn;
  logic                         next_dataWrEn;
  logic [`HBC_DATA_W-1:0]       next_dataWdata;

  // decode results
  hbc_pkg::hbc_alu_e            aluOp;
  hbc_pkg::hbc_branch_e         branch;
  logic                         useLit;         // b operand is literal
  logic                         fileRd;         // needs file operand
  logic                         fileWr;         // result goes to file
  logic                         wWr;            // result goes to working reg
  logic                         affC;
  logic                         affNc;
  logic                         affZ;
  logic                         skipOnZero;     // decrement/increment and skip
  logic                         bitTest;        // bit test and skip
  logic                         bitSet;         // bit op sets rather than clears
  // address and alu results
  logic [4:0]                   fileSel;
  logic [`HBC_DADDR_W-1:0]      effAddr;
  logic                         internalReg;
  logic [`HBC_DATA_W-1:0]       specialRead;
  logic [`HBC_DATA_W-1:0]       opB;
  logic [`HBC_DATA_W-1:0]       aluR;
  logic                         aluC;
  logic                         aluNc;
  logic [9:0]                   addOut;
  logic [`HBC_DATA_W-1:0]       bitMask;
  logic                         doSkip;
  logic                         pclWrite;

  // instruction decode, one 12-bit word per opcode
  always_comb begin
    aluOp      = hbc_pkg::ALU_PASS_W;
    branch     = hbc_pkg::BR_NONE;
    useLit     = 1'b0;
    fileRd     = 1'b0;
    fileWr     = 1'b0;
    wWr        = 1'b0;
    affC       = 1'b0;
    affNc      = 1'b0;
    affZ       = 1'b0;
    skipOnZero = 1'b0;
    bitTest    = 1'b0;
    bitSet     = 1'b0;
    case (ir[11:10])
      2'b00: begin
        if (ir[9:6] == 4'h0) begin
          // move w to file when bit 5 is set; rest are no-ops
          if (ir[5]) begin
            fileWr = 1'b1;
          end else if (ir[4:0] == 5'h00 && ir[9:6] == 4'h0 && ir[5:0] == 6'h00) begin
            aluOp = hbc_pkg::ALU_PASS_W;
          end
        end else if (ir[9:6] == 4'h1) begin
          aluOp = hbc_pkg::ALU_CLR;
          affZ  = 1'b1;
          fileWr = ir[5];
          wWr    = ~ir[5] & (ir[4:0] == 5'h00);
        end else begin
          // file operations with destination bit
          fileRd = 1'b1;
          fileWr = ir[`HBC_D_BIT];
          wWr    = ~ir[`HBC_D_BIT];
          case (ir[9:6])
            4'h2: begin aluOp = hbc_pkg::ALU_SUB; affC = 1'b1; affNc = 1'b1; affZ = 1'b1; end
            4'h3: begin aluOp = hbc_pkg::ALU_DEC; affZ = 1'b1; end
            4'h4: begin aluOp = hbc_pkg::ALU_IOR; affZ = 1'b1; end
            4'h5: begin aluOp = hbc_pkg::ALU_AND; affZ = 1'b1; end
            4'h6: begin aluOp = hbc_pkg::ALU_XOR; affZ = 1'b1; end
            4'h7: begin aluOp = hbc_pkg::ALU_ADD; affC = 1'b1; affNc = 1'b1; affZ = 1'b1; end
            4'h8: begin aluOp = hbc_pkg::ALU_PASS_F; affZ = 1'b1; end
            4'h9: begin aluOp = hbc_pkg::ALU_COM; affZ = 1'b1; end
            4'hA: begin aluOp = hbc_pkg::ALU_INC; affZ = 1'b1; end
            4'hB: begin aluOp = hbc_pkg::ALU_DEC; skipOnZero = 1'b1; end
            4'hC: begin aluOp = hbc_pkg::ALU_RRF; affC = 1'b1; end
            4'hD: begin aluOp = hbc_pkg::ALU_RLF; affC = 1'b1; end
            4'hE: begin aluOp = hbc_pkg::ALU_SWAP; end
            default: begin aluOp = hbc_pkg::ALU_INC; skipOnZero = 1'b1; end
          endcase
        end
      end
      2'b01: begin
        // bit clear, bit set, bit tests
        aluOp  = hbc_pkg::ALU_BITOP;
        fileRd = 1'b1;
        bitSet = ir[8];
        fileWr = ~ir[9];
        bitTest = ir[9];
      end
      2'b10: begin
        // return with literal, call, goto
        aluOp = hbc_pkg::ALU_PASS_L;
        if (ir[9:8] == 2'b00) begin
          branch = hbc_pkg::BR_RET;
          wWr    = 1'b1;
        end else if (ir[9:8] == 2'b01) begin
          branch = hbc_pkg::BR_CALL;
        end else begin
          branch = hbc_pkg::BR_GOTO;
        end
      end
      default: begin
        // literal operations against w
        useLit = 1'b1;
        wWr    = 1'b1;
        case (ir[9:8])
          2'b00:   aluOp = hbc_pkg::ALU_PASS_L;
          2'b01:   begin aluOp = hbc_pkg::ALU_IOR; affZ = 1'b1; end
          2'b10:   begin aluOp = hbc_pkg::ALU_AND; affZ = 1'b1; end
          default: begin aluOp = hbc_pkg::ALU_XOR; affZ = 1'b1; end
        endcase
      end
    endcase
  end

  // operand addressing and special register read
  always_comb begin
    fileSel     = ir[`HBC_F_MSB:0];
    // address zero selects the register the pointer names
    effAddr     = (fileSel == `HBC_ADDR_INDIRECT) ? pointer[`HBC_DADDR_W-1:0]
                                                  : {pointer[6:5], fileSel};
    internalReg = (effAddr[4:0] == `HBC_ADDR_INDIRECT) || (effAddr[4:0] == `HBC_ADDR_PCL) ||
                  (effAddr[4:0] == `HBC_ADDR_STATUS) || (effAddr[4:0] == `HBC_ADDR_POINTER);
    // special registers answer like file registers
    if (effAddr[4:0] == `HBC_ADDR_PCL) begin
      specialRead = progAddr[7:0];
    end else if (effAddr[4:0] == `HBC_ADDR_STATUS) begin
      specialRead = status;
    end else if (effAddr[4:0] == `HBC_ADDR_POINTER) begin
      specialRead = pointer;
    end else begin
      specialRead = 8'h00;
    end
  end

  // eight-bit alu; a is always w, b is file or literal
  always_comb begin
    opB     = useLit ? ir[`HBC_K_MSB:0] : operand;
    bitMask = 8'h01 << ir[`HBC_BIT_MSB:`HBC_BIT_LSB];
    addOut  = 10'h000;
    aluR    = 8'h00;
    aluC    = status[`HBC_ST_C];
    aluNc   = status[`HBC_ST_NC];
    case (aluOp)
      hbc_pkg::ALU_PASS_W: aluR = wReg;
      hbc_pkg::ALU_PASS_F: aluR = opB;
      hbc_pkg::ALU_PASS_L: aluR = ir[`HBC_K_MSB:0];
      hbc_pkg::ALU_CLR:    aluR = 8'h00;
      hbc_pkg::ALU_ADD: begin
        addOut = hbc_add(opB, wReg, 1'b0);
        {aluC, aluNc, aluR} = addOut;
      end
      hbc_pkg::ALU_SUB: begin
        // file minus w as file plus inverted w plus one
        addOut = hbc_add(opB, ~wReg, 1'b1);
        {aluC, aluNc, aluR} = addOut;
      end
      hbc_pkg::ALU_INC: begin
        addOut = hbc_add(opB, 8'h00, 1'b1);
        aluR   = addOut[7:0];
      end
      hbc_pkg::ALU_DEC: begin
        addOut = hbc_add(opB, 8'hFF, 1'b0);
        aluR   = addOut[7:0];
      end
      hbc_pkg::ALU_AND:  aluR = wReg & opB;
      hbc_pkg::ALU_IOR:  aluR = wReg | opB;
      hbc_pkg::ALU_XOR:  aluR = wReg ^ opB;
      hbc_pkg::ALU_COM:  aluR = ~opB;
      hbc_pkg::ALU_RRF: begin
        aluR = {status[`HBC_ST_C], opB[7:1]};
        aluC = opB[0];
      end
      hbc_pkg::ALU_RLF: begin
        aluR = {opB[6:0], status[`HBC_ST_C]};
        aluC = opB[7];
      end
      hbc_pkg::ALU_SWAP: aluR = {opB[3:0], opB[7:4]};
      default:           aluR = bitSet ? (opB | bitMask) : (opB & ~bitMask);
    endcase
    // skip conditions and pc writes through the data space
    doSkip   = irValid && ((skipOnZero && aluR == 8'h00) ||
               (bitTest && (((opB & bitMask) != 8'h00) == ir[8])));
    pclWrite = irValid && fileWr && (effAddr[4:0] == `HBC_ADDR_PCL);
  end

  // phase divider: one phase per clock, four per instruction cycle
  always_comb begin
    case (phase)
      hbc_pkg::Q1: next_phase = hbc_pkg::Q2;
      hbc_pkg::Q2: next_phase = hbc_pkg::Q3;
      hbc_pkg::Q3: next_phase = hbc_pkg::Q4;
      default:     next_phase = hbc_pkg::Q1;
    endcase
  end

  // phase register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= hbc_pkg::Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // next values of the datapath per phase
  always_comb begin
    next_pc        = pc;
    next_progAddr  = progAddr;
    next_ir        = ir;
    next_irValid   = irValid;
    next_wReg      = wReg;
    next_status    = status;
    next_pointer   = pointer;
    next_operand   = operand;
    next_stack0    = stack0;
    next_stack1    = stack1;
    next_dataAddr  = dataAddr;
    next_dataRdEn  = 1'b0;
    next_dataWrEn  = 1'b0;
    next_dataWdata = dataWdata;
    case (phase)
      hbc_pkg::Q1: begin
        // present fetch address and advance; set up operand read
        next_progAddr = pc;
        next_pc       = pc + 10'h001;
        next_dataAddr = effAddr;
        next_dataRdEn = irValid && fileRd && !internalReg;
      end
      hbc_pkg::Q2: begin
        // operand read from ram or special register
        next_operand = internalReg ? specialRead : dataRdata;
      end
      hbc_pkg::Q3: begin
        // drive ram write for the Q4 slot
        next_dataWrEn  = irValid && fileWr && !internalReg;
        next_dataWdata = aluR;
      end
      default: begin
        // Q4: commit result, latch next word, resolve branches
        next_ir      = progRdata;
        next_irValid = 1'b1;
        if (irValid) begin
          if (wWr) begin
            next_wReg = aluR;
          end
          if (fileWr && internalReg) begin
            if (effAddr[4:0] == `HBC_ADDR_STATUS) begin
              next_status = aluR;
            end else if (effAddr[4:0] == `HBC_ADDR_POINTER) begin
              next_pointer = aluR;
            end
          end
          if (affC) begin
            next_status[`HBC_ST_C] = aluC;
          end
          if (affNc) begin
            next_status[`HBC_ST_NC] = aluNc;
          end
          if (affZ) begin
            next_status[`HBC_ST_Z] = (aluR == 8'h00);
          end
          // any pc change or skip discards the word just fetched
          if (branch == hbc_pkg::BR_GOTO) begin
            next_pc      = {status[`HBC_ST_PA], ir[`HBC_GOTO_MSB:0]};
            next_irValid = 1'b0;
          end else if (branch == hbc_pkg::BR_CALL) begin
            next_stack1  = stack0;
            next_stack0  = progAddr;
            next_pc      = {status[`HBC_ST_PA], 1'b0, ir[`HBC_K_MSB:0]};
            next_irValid = 1'b0;
          end else if (branch == hbc_pkg::BR_RET) begin
            next_pc      = stack0;
            next_stack0  = stack1;
            next_irValid = 1'b0;
          end else if (pclWrite) begin
            next_pc      = {status[`HBC_ST_PA], 1'b0, aluR};
            next_irValid = 1'b0;
          end else if (doSkip) begin
            next_irValid = 1'b0;
          end
        end
      end
    endcase
  end

  // datapath registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc        <= `HBC_RESET_PC;
      progAddr  <= `HBC_RESET_PC;
      ir        <= `HBC_RESET_INSTR;
      irValid   <= 1'b0;
      wReg      <= `HBC_RESET_W;
      status    <= `HBC_RESET_STATUS;
      pointer   <= `HBC_RESET_PTR;
      operand   <= 8'h00;
      stack0    <= `HBC_RESET_PC;
      stack1    <= `HBC_RESET_PC;
      dataAddr  <= 7'h00;
      dataRdEn  <= 1'b0;
      dataWrEn  <= 1'b0;
      dataWdata <= 8'h00;
    end else begin
      pc        <= next_pc;
      progAddr  <= next_progAddr;
      ir        <= next_ir;
      irValid   <= next_irValid;
      wReg      <= next_wReg;
      status    <= next_status;
      pointer   <= next_pointer;
      operand   <= next_operand;
      stack0    <= next_stack0;
      stack1    <= next_stack1;
      dataAddr  <= next_dataAddr;
      dataRdEn  <= next_dataRdEn;
      dataWrEn  <= next_dataWrEn;
      dataWdata <= next_dataWdata;
    end
  end

endmodule : hbc_core

// *** design/hbc_defines.svh ***
/*
  constants of the 8-bit harvard core: widths, field positions,
  special register addresses, reset values and phase timing.
  assumes it is included by its bare name before the package and core.
*/
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH

// widths
`define HBC_INSTR_W      12
`define HBC_DATA_W       8
`define HBC_PADDR_W      10
`define HBC_DADDR_W      7
`define HBC_PROG_WORDS   1024

// instruction fields
`define HBC_F_MSB        4
`define HBC_D_BIT        5
`define HBC_BIT_MSB      7
`define HBC_BIT_LSB      5
`define HBC_K_MSB        7
`define HBC_GOTO_MSB     8

// special register addresses (low five address bits, mirrored per bank)
`define HBC_ADDR_INDIRECT 5'h00
`define HBC_ADDR_PCL      5'h02
`define HBC_ADDR_STATUS   5'h03
`define HBC_ADDR_POINTER  5'h04

// status bit positions
`define HBC_ST_C         0
`define HBC_ST_NC        1
`define HBC_ST_Z         2
`define HBC_ST_PA        5

// reset values
`define HBC_RESET_PC     10'h000
`define HBC_RESET_STATUS 8'h18
`define HBC_RESET_W      8'h00
`define HBC_RESET_PTR    8'h00
`define HBC_RESET_INSTR  12'h000

// timing: one q phase per clock, four phases per instruction cycle
`define HBC_CLK_MHZ      25
`define HBC_Q_PER_CYCLE  4
`define HBC_CYCLE_NS     ((`HBC_Q_PER_CYCLE * 1000) / `HBC_CLK_MHZ)

`endif

// *** design/hbc_pkg.sv ***
/*
  types of the 8-bit harvard core: phase, alu operation and branch kind.
  assumes hbc_defines.svh is available for widths.
*/
package hbc_pkg;

  // instruction cycle phases
  typedef enum logic [1:0] {
    Q1,
    Q2,
    Q3,
    Q4
  } hbc_phase_e;

  // alu operations
  typedef enum logic [3:0] {
    ALU_PASS_W,
    ALU_PASS_F,
    ALU_PASS_L,
    ALU_CLR,
    ALU_ADD,
    ALU_SUB,
    ALU_INC,
    ALU_DEC,
    ALU_AND,
    ALU_IOR,
    ALU_XOR,
    ALU_COM,
    ALU_RRF,
    ALU_RLF,
    ALU_SWAP,
    ALU_BITOP
  } hbc_alu_e;

  // program counter changes
  typedef enum logic [1:0] {
    BR_NONE,
    BR_GOTO,
    BR_CALL,
    BR_RET
  } hbc_branch_e;

endpackage : hbc_pkg

// *** tb/hbc_core_monitor.sv ***
/*
  checker for the harvard core: phase slots of the buses, fetch spacing,
  result write timing and which addresses reach the data bus.
  assumes it is bound to hbc_core and that phase q1 follows reset release.
*/
`timescale 1ns/1ps
`include "hbc_defines.svh"

module hbc_core_monitor (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // program bus
  input wire logic [`HBC_PADDR_W-1:0] progAddr,
  input wire logic [`HBC_INSTR_W-1:0] progRdata,
  // data bus
  input wire logic [`HBC_DADDR_W-1:0] dataAddr,
  input wire logic                    dataRdEn,
  input wire logic [`HBC_DATA_W-1:0]  dataRdata,
  input wire logic                    dataWrEn,
  input wire logic [`HBC_DATA_W-1:0]  dataWdata,
  // observation
  input wire logic [`HBC_DATA_W-1:0]  wReg,
  input wire logic [`HBC_DATA_W-1:0]  status
);
  logic [1:0] phase;       // 0 during q1 .. 3 during q4
  logic [1:0] next_phase;  // following phase

  // phase follows release of reset by a plain count
  always_comb begin
    next_phase = phase + 2'd1;
  end

  // phase register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'd0;
    end else begin
      phase <= next_phase;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // program address stands for the rest of the cycle
  sequence s_fetch_hold;
    $stable(progAddr)[*3];
  endsequence

  // a strobe may only be seen in its own phase
  property p_in_slot(logic en, logic [1:0] slot);
    en |-> phase == slot;
  endproperty

  a_read_in_q2:   assert property (p_in_slot(dataRdEn, 2'd1))
    else $error("data read outside q2");
  a_write_in_q4:  assert property (p_in_slot(dataWrEn, 2'd3))
    else $error("data write outside q4");
  a_pc_step_q1:   assert property ($changed(progAddr) |-> phase == 2'd1)
    else $error("program address moved outside q1 end");
  a_fetch_held:   assert property (phase == 2'd1 |=> s_fetch_hold)
    else $error("program address not held for the cycle");
  a_write_addr:   assert property (dataWrEn |-> dataAddr == $past(dataAddr, 2))
    else $error("write address differs from read address");
  a_internal_reg: assert property ((dataRdEn || dataWrEn) |->
                    !(dataAddr[4:0] inside {5'h00, 5'h02, 5'h03, 5'h04}))
    else $error("internal register reached the data bus");
  a_wreg_at_q4:   assert property ($changed(wReg) |-> phase == 2'd0)
    else $error("working register changed outside q4 end");
  a_status_at_q4: assert property ($changed(status) |-> phase == 2'd0)
    else $error("status changed outside q4 end");

endmodule : hbc_core_monitor

// *** tb/hbc_mem_model.sv ***
/*
  far side of the core: program flash and data ram.
  assumes the bench loads prog and ram by hierarchy while reset is held.
*/
`timescale 1ns/1ps
`include "hbc_defines.svh"

module hbc_mem_model (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     resetn,
  // pacing: slow flash answers one clock later
  input wire logic                     slowProg,
  // program bus
  input wire logic [`HBC_PADDR_W-1:0]  progAddr,
  output logic [`HBC_INSTR_W-1:0]      progRdata,
  // data bus
  input wire logic [`HBC_DADDR_W-1:0]  dataAddr,
  input wire logic                     dataRdEn,
  output logic [`HBC_DATA_W-1:0]       dataRdata,
  input wire logic                     dataWrEn,
  input wire logic [`HBC_DATA_W-1:0]   dataWdata
);
  logic [`HBC_INSTR_W-1:0] prog [0:`HBC_PROG_WORDS-1];
  logic [`HBC_DATA_W-1:0]  ram  [0:127];
  logic [`HBC_PADDR_W-1:0] lastAddr;                    // address last presented
  logic [`HBC_DATA_W-1:0]  lastRd = 8'h5A;              // last byte read out

  // flash: one whole word per address, garbage while a slow read settles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastAddr  <= '1;
      progRdata <= 12'h000;
    end else if (progAddr != lastAddr) begin
      lastAddr  <= progAddr;
      progRdata <= slowProg ? ~progRdata : prog[progAddr];
    end else begin
      progRdata <= prog[progAddr];
    end
  end

  // ram read only while selected, inverse of last byte otherwise
  assign dataRdata = dataRdEn ? ram[dataAddr] : ~lastRd;

  // ram write and read history
  always @(posedge clk) begin
    if (dataRdEn) begin
      lastRd <= ram[dataAddr];
    end
    if (dataWrEn) begin
      ram[dataAddr] <= dataWdata;
    end
  end

endmodule : hbc_mem_model

// *** tb/tb_top.sv ***
/*
  bench for the harvard core: runs short programs from the memory model
  and judges results, flags, fetch order and timing at the ports.
  assumes the design, its defines and the model and checker files.
*/
`timescale 1ns/1ps
`include "hbc_defines.svh"

module tb_top;
  logic                    clk = 1'b0;     // 25 MHz
  logic                    resetn = 1'b0;  // held from time zero
  logic                    slowProg = 1'b0;
  logic [`HBC_PADDR_W-1:0] progAddr;
  logic [`HBC_INSTR_W-1:0] progRdata;
  logic [`HBC_DADDR_W-1:0] dataAddr;
  logic                    dataRdEn;
  logic [`HBC_DATA_W-1:0]  dataRdata;
  logic                    dataWrEn;
  logic [`HBC_DATA_W-1:0]  dataWdata;
  logic [`HBC_DATA_W-1:0]  wReg;
  logic [`HBC_DATA_W-1:0]  status;
  logic [11:0]             prg [$];        // program of the current test
  int                      miscompares = 0;
  int                      checkCount = 0;

  // clock
  initial begin
    forever #20 clk = ~clk;
  end

  hbc_core dut (.clk(clk), .resetn(resetn), .progAddr(progAddr), .progRdata(progRdata),
    .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdata(dataRdata), .dataWrEn(dataWrEn),
    .dataWdata(dataWdata), .wReg(wReg), .status(status));

  hbc_mem_model mem (.clk(clk), .resetn(resetn), .slowProg(slowProg), .progAddr(progAddr),
    .progRdata(progRdata), .dataAddr(dataAddr), .dataRdEn(dataRdEn),
    .dataRdata(dataRdata), .dataWrEn(dataWrEn), .dataWdata(dataWdata));

  // compare one value
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // n rising edges, then sample once they have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // reset (mid-run after the first test), load program, release at an edge
  task automatic start_prog(input logic slow);
    @(posedge clk);
    resetn   <= 1'b0;
    slowProg <= slow;
    for (int i = 0; i < `HBC_PROG_WORDS; i++) begin
      mem.prog[i] = (i < prg.size()) ? prg[i] : 12'h000;
    end
    for (int i = 0; i < 128; i++) begin
      mem.ram[i] = 8'h00;
    end
    step(1);
    check("reset progAddr", progAddr, 10'h000);
    check("reset wReg", wReg, 8'h00);
    check("reset status", status, 8'h18);
    check("reset rd", dataRdEn, 1'b0);
    check("reset wr", dataWrEn, 1'b0);
    @(posedge clk);
    resetn <= 1'b1;
  endtask : start_prog

  // add with carries out of both nibbles and a zero result
  task automatic test_add();
    prg = '{12'hC8F, 12'h030, 12'hC71, 12'h1D0, 12'hA04};
    start_prog(1'b0);
    step(24);
    check("add w", wReg, 8'h00);
    check("add flags", status, 8'h1F);
    check("add file", mem.ram[16], 8'h8F);
    $display("test_add done");
  endtask : test_add

  // subtraction without and with borrow, to file then to w
  task automatic test_sub();
    prg = '{12'hC10, 12'h031, 12'hC01, 12'h0B1, 12'hC20, 12'h091, 12'hA06};
    start_prog(1'b0);
    step(20);
    check("sub file", mem.ram[17], 8'h0F);
    check("sub flags a", status, 8'h19);
    step(8);
    check("sub w", wReg, 8'hEF);
    check("sub flags b", status, 8'h1A);
    $display("test_sub done");
  endtask : test_sub

  // jump over one word with slow flash: fetch order and cycle timing
  task automatic test_branch();
    logic [9:0] ea [7];
    logic [7:0] ew [7];
    ea = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h004};
    ew = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h81, 8'h81};
    prg = '{12'hC01, 12'hA03, 12'hC55, 12'hD80, 12'hA04};
    start_prog(1'b1);
    for (int k = 0; k < 7; k++) begin
      step(k == 0 ? 1 : 4);
      check("fetch addr", progAddr, ea[k]);
      check("pipe w", wReg, ew[k]);
    end
    $display("test_branch done");
  endtask : test_branch

  // indirect write, rotate, literal logic, file move and pc low read
  task automatic test_indirect();
    prg = '{12'hC15, 12'h024, 12'hCA5, 12'h020, 12'h360, 12'hE0F, 12'hF05, 12'h215,
            12'h202, 12'hA09};
    start_prog(1'b0);
    step(32);
    check("logic zero", status, 8'h1D);
    step(4);
    check("move file", wReg, 8'h4A);
    step(4);
    check("pc low", wReg, 8'h09);
    check("rot flags", status, 8'h19);
    check("rot ram", mem.ram[21], 8'h4A);
    $display("test_indirect done");
  endtask : test_indirect

  // call, return with literal, decrement-skip, bit set, bit test skip, swap
  task automatic test_call();
    prg = '{12'hC01, 12'h030, 12'h90A, 12'h2F0, 12'hC77, 12'h5F0, 12'h7F0, 12'hC77,
            12'h390, 12'hA09, 12'h83C};
    start_prog(1'b0);
    step(24);
    check("ret w", wReg, 8'h3C);
    step(8);
    check("dec file", mem.ram[16], 8'h00);
    check("dec flags", status, 8'h18);
    step(8);
    check("skip dec", wReg, 8'h3C);
    check("bit set", mem.ram[16], 8'h80);
    step(8);
    check("skip bit", wReg, 8'h3C);
    step(4);
    check("swap w", wReg, 8'h08);
    $display("test_call done");
  endtask : test_call

  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    test_add();
    test_sub();
    test_branch();
    test_indirect();
    test_call();
    wrap_up();
  end

  // watchdog: about ten times the expected run
  initial begin
    #(40 * 2000);
    miscompares++;
    wrap_up();
  end

endmodule : tb_top

bind hbc_core hbc_core_monitor u_mon (.clk(clk), .resetn(resetn), .progAddr(progAddr),
  .progRdata(progRdata), .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataRdata(dataRdata),
  .dataWrEn(dataWrEn), .dataWdata(dataWdata), .wReg(wReg), .status(status));
